//--- common/pswr_pkg.sv
package pswr_pkg;
   // timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int POR_SAMPLE_NS = 1000;
   localparam int POR_SAMPLE_CYC = (POR_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // wake-up packet capture
   localparam int CAPTURE_BYTES = 128;
   // register offsets
   localparam logic [7:0] OFF_PMCSR = 8'h00;
   localparam logic [7:0] OFF_PMCAP = 8'h04;
   localparam logic [7:0] OFF_DRVSTAT = 8'h08;
   localparam logic [7:0] OFF_MACCFG = 8'h0c;
   localparam logic [7:0] OFF_STATE = 8'h10;
   localparam logic [7:0] OFF_BUF_BASE = 8'h80;
   // pm control/status fields
   localparam int PMCSR_PS_LSB = 0;
   localparam int PMCSR_PME_EN_BIT = 8;
   localparam int PMCSR_PME_STS_BIT = 15;
   localparam int PMCAP_AUX_BIT = 15;
   // driver status fields
   localparam int DRV_PATTERN_BIT = 0;
   localparam int DRV_MAGIC_BIT = 1;
   localparam int DRV_LINK_BIT = 2;
   localparam int DRV_MGMT_BIT = 3;
   // mac configuration fields
   localparam int MACCFG_WAKE_EN_BIT = 0;
   localparam int MACCFG_BAR_BIT = 1;
   // state readout fields
   localparam int STATE_PS_LSB = 0;
   localparam int STATE_LINK_BIT = 4;
   localparam int STATE_STORED_BIT = 8;
   localparam int STATE_LEN_LSB = 16;
   // reset values
   localparam logic PME_EN_RST = 1'b0;
   localparam logic MAC_WAKE_EN_RST = 1'b0;
   localparam logic [3:0] DRVSTAT_RST = 4'h0;
   localparam logic [3:0] PIN_SYNC_RST = 4'h7;
   // power state codes
   localparam logic [1:0] PS_CODE_D0 = 2'h0;
   localparam logic [1:0] PS_CODE_D1 = 2'h1;
   localparam logic [1:0] PS_CODE_D2 = 2'h2;
   localparam logic [1:0] PS_CODE_D3 = 2'h3;

   typedef enum logic [2:0] {PS_D0U, PS_D0A, PS_D1, PS_D2, PS_D3} pswr_pstate_t;
endpackage : pswr_pkg

//--- dv/pswr_host_model.sv
`timescale 1ns/1ns
module pswr_host_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // bus power requests
   input wire logic pwr_off,
   input wire logic warm_rst,
   // reset pins to the device
   output logic isolate_n,
   output logic bus_reset_n
);
   // isolate follows bus power, bus reset also covers warm boot
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         isolate_n <= 1'b1;
         bus_reset_n <= 1'b1;
      end else begin
         isolate_n <= !pwr_off;
         bus_reset_n <= !(pwr_off || warm_rst);
      end
   end
endmodule : pswr_host_model

//--- dv/tb.sv
`timescale 1ns/1ns
module tb;
   import pswr_pkg::*;
   // pins, straps, receive path, register port
   logic sys_clk, rst_n, alt_n, strap, offload, ctrl, link, pwr_off, warm, iso_n, brst_n;
   logic rx_valid, rx_sop, rx_eop, hit_p, hit_m, hit_g, reg_wr, reg_rd;
   logic [7:0] rx_data, reg_addr, b0, b127;
   logic [31:0] reg_wdata, reg_rdata;
   logic pme_n, out_en, master, init, keep, watch, fwd;
   logic [15:0] seed;
   int fails, checked, inits, fwds, n0;
   int lens[4], hits[4], drvs[4];
   pswr_ctrl #(.POR_CYC(4)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .alternate_power_on_reset_n(alt_n),
      .isolate_n(iso_n), .bus_reset_n(brst_n), .aux_supply_present_strap(strap),
      .manageability_offload(offload), .mgmt_ctrl_present(ctrl), .link_valid(link), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_sop(rx_sop), .rx_eop(rx_eop), .rx_pattern_hit(hit_p), .rx_magic_hit(hit_m),
      .rx_mgmt_hit(hit_g), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .pme_event_n(pme_n), .bus_out_en(out_en), .bus_master_allow(master),
      .internal_init(init), .link_keep(keep), .link_detect_only(watch), .mgmt_fwd(fwd));
   pswr_host_model u_host (.sys_clk(sys_clk), .rst_n(rst_n), .pwr_off(pwr_off), .warm_rst(warm),
      .isolate_n(iso_n), .bus_reset_n(brst_n));
   // 250 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // count init and forward pulses
   always @(posedge sys_clk) begin
      inits <= inits + (init === 1'b1);
      fwds <= fwds + (fwd === 1'b1);
   end
   ////////////////////////////////////////
   function automatic logic [15:0] nxt(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : nxt
   function automatic logic [31:0] pm(logic [1:0] ps, logic en, logic sts);
      return 32'(ps) | (32'(en) << PMCSR_PME_EN_BIT) | (32'(sts) << PMCSR_PME_STS_BIT);
   endfunction : pm
   task automatic chk(string what, logic [31:0] got, logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic cyc(int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge sys_clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   // read one word and compare the masked bits
   task automatic rc(string what, logic [7:0] a, logic [31:0] m, logic [31:0] exp);
      @(posedge sys_clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(what, reg_rdata & m, exp);
   endtask : rc
   // send one frame of random bytes with one filter hit
   task automatic pkt(int len, int hit, int kind);
      for (int i = 0; i < len; i++) begin
         @(posedge sys_clk);
         seed = nxt(seed);
         if (i == 0) b0 = seed[7:0];
         if (i == 127) b127 = seed[7:0];
         {rx_valid, rx_sop, rx_eop, rx_data} <= {1'b1, i == 0, i == len - 1, seed[7:0]};
         {hit_p, hit_m, hit_g} <= (i == hit) ? 3'h4 >> kind : 3'h0;
      end
      @(posedge sys_clk);
      {rx_valid, rx_sop, rx_eop, hit_p, hit_m, hit_g} <= 6'h0;
   endtask : pkt
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_of_test
   ////////////////////////////////////////
   // main sequence
   initial begin
      seed = 16'h1b6b;
      {rx_valid, rx_sop, rx_eop, hit_p, hit_m, hit_g, reg_wr, reg_rd} = 8'h0;
      {offload, ctrl, pwr_off, warm, rst_n, rx_data, reg_addr, reg_wdata} = 53'h0;
      {alt_n, strap, link} = 3'h7;
      lens = '{130 + seed[3:0], 150, 160, 64};
      hits = '{5, 128, 140, 2};
      drvs = '{1, 0, 2, 8};
      cyc(4);
      rst_n <= 1'b1;
      cyc(8);
      rc("aux", OFF_PMCAP, 32'h8000, 32'h8000);
      rc("d0u", OFF_STATE, 32'h7, 32'h0);
      rc("hole", 8'h44, 32'hffffffff, 32'h0);
      wr(OFF_MACCFG, 32'h2);
      rc("d0a", OFF_STATE, 32'h7, 32'h1);
      chk("master", master, 1'b1);
      link <= 1'b0;
      cyc(6);
      rc("no en", OFF_PMCSR, 32'hffffffff, 32'h0);
      wr(OFF_PMCSR, pm(PS_CODE_D0, 1'b1, 1'b0));
      link <= 1'b1;
      cyc(6);
      rc("sts", OFF_PMCSR, 32'hffffffff, pm(PS_CODE_D0, 1'b1, 1'b1));
      chk("gated", pme_n, 1'b1);
      wr(OFF_MACCFG, 32'h1);
      cyc(20);
      chk("held", pme_n, 1'b0);
      wr(OFF_PMCSR, pm(PS_CODE_D2, 1'b1, 1'b1));
      wr(OFF_DRVSTAT, 32'hf);
      link <= 1'b0;
      cyc(6);
      chk("watch", {watch, keep}, 2'h2);
      rc("d2 link", OFF_PMCSR, 32'hffffffff, pm(PS_CODE_D2, 1'b1, 1'b1));
      wr(OFF_PMCSR, pm(PS_CODE_D3, 1'b0, 1'b1));
      link <= 1'b1;
      cyc(6);
      chk("d3 off", {pme_n, keep}, 2'h2);
      offload <= 1'b1;
      cyc(4);
      chk("offload", keep, 1'b1);
      offload <= 1'b0;
      wr(OFF_PMCSR, pm(PS_CODE_D1, 1'b1, 1'b1));
      cyc(2);
      chk("d1 master", master, 1'b0);
      rc("d2 drv", OFF_DRVSTAT, 32'h4, 32'h4);
      wr(OFF_DRVSTAT, 32'hf);
      for (int k = 0; k < 4; k++) begin
         pkt(lens[k], hits[k], k < 2 ? 0 : k - 1);
         cyc(4);
         chk("wake", pme_n, drvs[k] == 0);
         rc("drv", OFF_DRVSTAT, 32'hf, drvs[k]);
         if (k < 3) rc("stored", OFF_STATE, 32'h100, k == 0 ? 32'h100 : 32'h0);
         if (k == 0) begin
            rc("len", OFF_STATE, 32'hff0000, 32'(CAPTURE_BYTES) << STATE_LEN_LSB);
            rc("byte0", OFF_BUF_BASE, 32'hff, 32'(b0));
            rc("byte127", 8'hfc, 32'hff000000, {b127, 24'h0});
         end
         wr(OFF_DRVSTAT, 32'hf);
         wr(OFF_PMCSR, pm(PS_CODE_D1, 1'b1, 1'b1));
      end
      ctrl <= 1'b1;
      n0 = fwds;
      pkt(40, 3, 2);
      cyc(4);
      chk("fwd", fwds - n0, 1);
      pkt(20, 0, 0);
      cyc(4);
      n0 = inits;
      warm <= 1'b1;
      cyc(8);
      warm <= 1'b0;
      cyc(8);
      chk("init d1", inits > n0, 1'b1);
      rc("kept", OFF_PMCSR, 32'hffffffff, pm(PS_CODE_D1, 1'b1, 1'b1));
      rc("kept buf", OFF_STATE, 32'h100, 32'h100);
      wr(OFF_PMCSR, pm(PS_CODE_D3, 1'b1, 1'b1));
      n0 = inits;
      warm <= 1'b1;
      cyc(8);
      chk("d3 held", inits, n0);
      warm <= 1'b0;
      cyc(8);
      chk("d3 edge", inits > n0, 1'b1);
      rc("d3 d0u", OFF_STATE, 32'h7, 32'h0);
      wr(OFF_MACCFG, 32'h3);
      wr(OFF_PMCSR, pm(PS_CODE_D0, 1'b0, 1'b0));
      warm <= 1'b1;
      cyc(8);
      warm <= 1'b0;
      cyc(8);
      rc("init cfg", OFF_MACCFG, 32'h1, 32'h0);
      rc("init st", OFF_STATE, 32'h7, 32'h0);
      wr(OFF_MACCFG, 32'h1);
      wr(OFF_PMCSR, pm(PS_CODE_D0, 1'b1, 1'b0));
      link <= 1'b0;
      pwr_off <= 1'b1;
      cyc(8);
      chk("iso", {out_en, pme_n}, 2'h0);
      rc("iso rd", OFF_PMCSR, 32'hffffffff, 32'h0);
      n0 = inits;
      pwr_off <= 1'b0;
      cyc(8);
      chk("iso end", {inits > n0, out_en}, 2'h3);
      strap <= 1'b0;
      alt_n <= 1'b0;
      cyc(4);
      alt_n <= 1'b1;
      cyc(12);
      rc("alt", OFF_PMCSR, 32'hffffffff, 32'h0);
      rc("alt aux", OFF_PMCAP, 32'h8000, 32'h0);
      end_of_test();
   end
   // watchdog, the sequence needs about 850 cycles
   initial begin
      cyc(20000);
      fails++;
      end_of_test();
   end
endmodule : tb

//--- hw/pswr_ctrl.sv
// Behaviour
// - deepest state with event disabled: no wake-up, link kept only with manageability offload
// - sample aux-supply strap during power-on reset, show it in pm capability
// - alternate reset low initialises power state, enables, status, stored packet, receive flags and strap window
// - internal power-on reset window samples configuration straps
// - while isolated ignore all host bus inputs, bus reset included
// - while isolated host outputs off, event output stays driven
// - isolate deassertion raises internal hardware reset
// - with event enabled, bus reset keeps status and stored packet, and pm state outside D3
// - bus reset trailing edge in D3 marks move to full power
// - init on bus reset in D0-D2, on its trailing edge in D3
// - init with event disabled resets configuration, mac configuration and stored packet
// - in D0 active full function, wake on link change
// - D2/D3 with invalid link: only watch for valid link
// - low power with event off: no wake; manageability keeps link
// - wake events recognised only while event enable is set
// - patterns matched in first 128 bytes, magic frame across whole frame
// - unmatched packet discarded, next packets processed
// - management packets forwarded to controller if present, else wake packet
// - store first 128 bytes of matched wake packet, drop the rest
// - magic frame wakes and sets status bit but is not stored
// - link status change reported in every power state
// - event output qualified by enable bit and mac configure setting
// - start in D0 uninitialised, go active on base address programming
// - in D1 start no bus activity
`timescale 1ns/1ns
module pswr_ctrl
   import pswr_pkg::*;
#(
   parameter int CAP_BYTES = CAPTURE_BYTES,
   parameter int POR_CYC = POR_SAMPLE_CYC
) (
   // clock and power-on reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // pins and strap
   input wire logic alternate_power_on_reset_n,
   input wire logic isolate_n,
   input wire logic bus_reset_n,
   input wire logic aux_supply_present_strap,
   // eeprom configuration
   input wire logic manageability_offload,
   input wire logic mgmt_ctrl_present,
   // receive path
   input wire logic link_valid,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_sop,
   input wire logic rx_eop,
   input wire logic rx_pattern_hit,
   input wire logic rx_magic_hit,
   input wire logic rx_mgmt_hit,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // status and control out
   output logic pme_event_n,
   output logic bus_out_en,
   output logic bus_master_allow,
   output logic internal_init,
   output logic link_keep,
   output logic link_detect_only,
   output logic mgmt_fwd
);
   localparam logic [7:0] CAP_LIM = 8'(CAP_BYTES);
   localparam logic [8:0] POR_LOAD = 9'(POR_CYC);

   // elaboration check of parameter ranges
   if (CAP_BYTES < 4 || CAP_BYTES > 128 || CAP_BYTES % 4 != 0) begin : g_bad_cap
      $error("CAP_BYTES must be a multiple of 4 in 4..128");
   end
   if (POR_CYC < 1 || POR_CYC > 511) begin : g_bad_por
      $error("POR_CYC must be in 1..511");
   end

   ////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [1:0] ps_code(input pswr_pstate_t s);
      case (s)
         PS_D1: ps_code = PS_CODE_D1;
         PS_D2: ps_code = PS_CODE_D2;
         PS_D3: ps_code = PS_CODE_D3;
         default: ps_code = PS_CODE_D0;
      endcase
   endfunction : ps_code

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [3:0] pin_s;
   pswr_sync2 #(.W(4), .RST_VAL(PIN_SYNC_RST)) u_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .d({aux_supply_present_strap, bus_reset_n, isolate_n, alternate_power_on_reset_n}),
      .q(pin_s)
   );

   logic alt_rst, iso, bus_rst_raw, bus_rst, aux_s;
   assign alt_rst = !pin_s[0];
   assign iso = !pin_s[1];
   assign bus_rst_raw = !pin_s[2];
   assign aux_s = pin_s[3];
   assign bus_rst = bus_rst_raw && !iso;

   ////////////////////////////////////////////////////////////////////////
   // state declarations
   pswr_pstate_t pm_state, next_pm_state;
   logic pme_en, pme_status, mac_wake_en, aux_cap;
   logic [3:0] drv_stat, next_drv_stat;
   logic iso_q, bus_rst_q, link_q;
   logic [8:0] por_cnt;
   logic stored_valid;
   logic [7:0] stored_len, rx_cnt;
   logic pat_seen, magic_seen, mgmt_seen;
   logic [7:0] cap_mem [CAP_BYTES];

   ////////////////////////////////////////////////////////////////////////
   // reset and edge detection
   logic bus_trail, iso_trail, init_req, por_active, low_power;
   assign bus_trail = !iso && bus_rst_q && !bus_rst_raw;
   assign iso_trail = iso_q && !iso;
   assign init_req = (bus_rst && pm_state != PS_D3)
      || (bus_trail && pm_state == PS_D3)
      || iso_trail;
   assign por_active = por_cnt != 9'h000;
   assign low_power = pm_state inside {PS_D1, PS_D2, PS_D3};

   // edge history; bus reset history frozen while isolated
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         iso_q <= 1'b0;
         bus_rst_q <= 1'b0;
      end else begin
         iso_q <= iso;
         if (!iso) begin
            bus_rst_q <= bus_rst_raw;
         end
      end
   end

   // strap sampling window, restarted by either power-on reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         por_cnt <= POR_LOAD;
      end else if (alt_rst) begin
         por_cnt <= POR_LOAD;
      end else if (por_active) begin
         por_cnt <= por_cnt - 9'h001;
      end
   end

   // aux strap captured while the window is open
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         aux_cap <= 1'b0;
      end else if (por_active) begin
         aux_cap <= aux_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register writes
   logic wr_en, wr_pmcsr, wr_drv, wr_mac, pme_clr;
   assign wr_en = reg_wr && !iso;
   assign wr_pmcsr = wr_en && reg_addr == OFF_PMCSR;
   assign wr_drv = wr_en && reg_addr == OFF_DRVSTAT;
   assign wr_mac = wr_en && reg_addr == OFF_MACCFG;
   assign pme_clr = wr_pmcsr && reg_wdata[PMCSR_PME_STS_BIT];

   // requested power state from the control field
   always_comb begin
      case (reg_wdata[PMCSR_PS_LSB +: 2])
         PS_CODE_D1: next_pm_state = PS_D1;
         PS_CODE_D2: next_pm_state = PS_D2;
         PS_CODE_D3: next_pm_state = PS_D3;
         default: next_pm_state = (pm_state == PS_D0U) ? PS_D0U : PS_D0A;
      endcase
   end

   // power state
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pm_state <= PS_D0U;
      end else if (alt_rst) begin
         pm_state <= PS_D0U;
      end else if (init_req && (!pme_en || pm_state == PS_D3)) begin
         pm_state <= PS_D0U;
      end else if (wr_pmcsr) begin
         pm_state <= next_pm_state;
      end else if (pm_state == PS_D0U && wr_mac && reg_wdata[MACCFG_BAR_BIT]) begin
         pm_state <= PS_D0A;
      end
   end

   // event enable and mac wake setting, kept over init while enabled
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pme_en <= PME_EN_RST;
         mac_wake_en <= MAC_WAKE_EN_RST;
      end else if (alt_rst) begin
         pme_en <= PME_EN_RST;
         mac_wake_en <= MAC_WAKE_EN_RST;
      end else if (init_req && !pme_en) begin
         mac_wake_en <= MAC_WAKE_EN_RST;
      end else begin
         if (wr_pmcsr) begin
            pme_en <= reg_wdata[PMCSR_PME_EN_BIT];
         end
         if (wr_mac) begin
            mac_wake_en <= reg_wdata[MACCFG_WAKE_EN_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // wake detection
   logic wake_allowed, capture_on, link_evt;
   logic [7:0] cur_idx;
   logic in_window, pkt_end, pat_now, magic_now, mgmt_now;
   logic pkt_wake, magic_evt, mgmt_to_ctrl, wake_evt;
   assign wake_allowed = pme_en && (!iso || aux_cap);
   assign capture_on = low_power && wake_allowed;
   assign link_evt = (link_valid ^ link_q) && wake_allowed;
   assign cur_idx = rx_sop ? 8'h00 : rx_cnt;
   assign in_window = cur_idx < CAP_LIM;
   assign pkt_end = rx_valid && rx_eop;
   assign pat_now = pat_seen || (rx_valid && rx_pattern_hit && in_window);
   assign magic_now = magic_seen || (rx_valid && rx_magic_hit);
   assign mgmt_now = mgmt_seen || (rx_valid && rx_mgmt_hit);
   assign mgmt_to_ctrl = pkt_end && capture_on && mgmt_now && mgmt_ctrl_present;
   assign pkt_wake = pkt_end && capture_on && (pat_now || (mgmt_now && !mgmt_ctrl_present));
   assign magic_evt = pkt_end && capture_on && magic_now;
   assign wake_evt = link_evt || pkt_wake || magic_evt;

   // link history
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         link_q <= 1'b0;
      end else begin
         link_q <= link_valid;
      end
   end

   // byte counter and per-packet match flags, dropped at frame end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_cnt <= 8'h00;
         pat_seen <= 1'b0;
         magic_seen <= 1'b0;
         mgmt_seen <= 1'b0;
      end else if (alt_rst) begin
         rx_cnt <= 8'h00;
         pat_seen <= 1'b0;
         magic_seen <= 1'b0;
         mgmt_seen <= 1'b0;
      end else if (rx_valid) begin
         if (cur_idx != 8'hff) begin
            rx_cnt <= cur_idx + 8'h01;
         end
         pat_seen <= pat_now && !rx_eop;
         magic_seen <= magic_now && !rx_eop;
         mgmt_seen <= mgmt_now && !rx_eop;
      end
   end

   // capture memory, frozen once a wake packet is held
   always_ff @(posedge sys_clk) begin
      if (rx_valid && in_window && capture_on && !stored_valid) begin
         cap_mem[cur_idx[6:0]] <= rx_data;
      end
   end

   // stored packet bookkeeping
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stored_valid <= 1'b0;
         stored_len <= 8'h00;
      end else if (alt_rst || (init_req && !pme_en)) begin
         stored_valid <= 1'b0;
         stored_len <= 8'h00;
      end else if (pkt_wake && !stored_valid) begin
         stored_valid <= 1'b1;
         stored_len <= in_window ? cur_idx + 8'h01 : CAP_LIM;
      end else if (wr_drv && reg_wdata[DRV_PATTERN_BIT]) begin
         stored_valid <= 1'b0;
      end
   end

   // driver status bits: hardware set wins over write-one-to-clear
   always_comb begin
      next_drv_stat = drv_stat;
      if (wr_drv) begin
         next_drv_stat = drv_stat & ~reg_wdata[3:0];
      end
      next_drv_stat[DRV_PATTERN_BIT] = next_drv_stat[DRV_PATTERN_BIT] | (pkt_wake && pat_now);
      next_drv_stat[DRV_MAGIC_BIT] = next_drv_stat[DRV_MAGIC_BIT] | magic_evt;
      next_drv_stat[DRV_LINK_BIT] = next_drv_stat[DRV_LINK_BIT] | link_evt;
      next_drv_stat[DRV_MGMT_BIT] = next_drv_stat[DRV_MGMT_BIT] | (pkt_wake && mgmt_now);
   end

   // sticky status registers
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         drv_stat <= DRVSTAT_RST;
         pme_status <= 1'b0;
      end else if (alt_rst || (init_req && !pme_en)) begin
         drv_stat <= DRVSTAT_RST;
         pme_status <= 1'b0;
      end else begin
         drv_stat <= next_drv_stat;
         pme_status <= (pme_status && !pme_clr) || wake_evt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered outputs
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pme_event_n <= 1'b1;
         bus_out_en <= 1'b0;
         bus_master_allow <= 1'b0;
         internal_init <= 1'b0;
         mgmt_fwd <= 1'b0;
      end else begin
         pme_event_n <= !(pme_status && pme_en && mac_wake_en);
         bus_out_en <= !iso;
         bus_master_allow <= !iso && pm_state == PS_D0A;
         internal_init <= init_req && !alt_rst;
         mgmt_fwd <= mgmt_to_ctrl;
      end
   end

   // link maintenance per power state
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         link_keep <= 1'b1;
         link_detect_only <= 1'b0;
      end else begin
         if (!low_power) begin
            link_keep <= 1'b1;
         end else if (!wake_allowed) begin
            link_keep <= manageability_offload;
         end else if (pm_state == PS_D1) begin
            link_keep <= 1'b1;
         end else begin
            link_keep <= link_valid;
         end
         link_detect_only <= low_power && wake_allowed && pm_state != PS_D1 && !link_valid;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register reads, data valid the cycle after the strobe
   logic [31:0] rd_val;
   logic [6:0] bidx;
   always_comb begin
      rd_val = 32'h0000_0000;
      bidx = {reg_addr[6:2], 2'b00};
      if (reg_addr >= OFF_BUF_BASE) begin
         for (int k = 0; k < 4; k++) begin
            if (int'(bidx) + k < CAP_BYTES) begin
               rd_val[8*k +: 8] = cap_mem[int'(bidx) + k];
            end
         end
      end else begin
         case (reg_addr)
            OFF_PMCSR: begin
               rd_val[PMCSR_PS_LSB +: 2] = ps_code(pm_state);
               rd_val[PMCSR_PME_EN_BIT] = pme_en;
               rd_val[PMCSR_PME_STS_BIT] = pme_status;
            end
            OFF_PMCAP: rd_val[PMCAP_AUX_BIT] = aux_cap;
            OFF_DRVSTAT: rd_val[3:0] = drv_stat;
            OFF_MACCFG: rd_val[MACCFG_WAKE_EN_BIT] = mac_wake_en;
            OFF_STATE: begin
               rd_val[STATE_PS_LSB +: 3] = pm_state;
               rd_val[STATE_LINK_BIT] = link_valid;
               rd_val[STATE_STORED_BIT] = stored_valid;
               rd_val[STATE_LEN_LSB +: 8] = stored_len;
            end
            default: rd_val = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else begin
         reg_rdata <= (reg_rd && !iso) ? rd_val : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   chk_iso_outputs_off: assert property (iso |=> !bus_out_en && !bus_master_allow)
      else $error("host outputs enabled while isolated");
   chk_pme_driven_iso: assert property (iso && pme_status && pme_en && mac_wake_en |=> !pme_event_n)
      else $error("event output not driven while isolated");
   chk_pme_gated: assert property (!pme_en || !mac_wake_en |=> pme_event_n)
      else $error("event output asserted without enable");
   chk_pme_held: assert property (pme_status && !pme_clr && !alt_rst && !(init_req && !pme_en) |=> pme_status)
      else $error("event status dropped without clear");
   chk_init_bus_rst: assert property (bus_rst && pm_state != PS_D3 && !alt_rst |=> internal_init)
      else $error("no init on bus reset in D0-D2");
   chk_init_d3_trail: assert property (bus_trail && pm_state == PS_D3 && !alt_rst |=> internal_init && pm_state == PS_D0U)
      else $error("no init at bus reset trailing edge in D3");
   chk_init_iso_trail: assert property (iso_q && !iso && !alt_rst |=> internal_init)
      else $error("no init at isolate release");
   chk_iso_ignores_wr: assert property (iso && !alt_rst |=> $stable(pme_en))
      else $error("register changed while isolated");
   chk_alt_reset_all: assert property (alt_rst |=> pm_state == PS_D0U && !pme_en && !stored_valid)
      else $error("alternate reset left state");
   chk_aux_sample: assert property (por_active && !alt_rst |=> aux_cap == $past(aux_s))
      else $error("aux strap not sampled in window");
   chk_no_wake_off: assert property (!wake_allowed && !pme_status && !alt_rst |=> !pme_status)
      else $error("wake recognised with enable off");
   chk_link_off_deep: assert property (low_power && !wake_allowed && !manageability_offload |=> !link_keep)
      else $error("link kept with event off");
   chk_d1_no_master: assert property (pm_state == PS_D1 |=> !bus_master_allow)
      else $error("bus activity allowed in D1");
   chk_store_limit: assert property (stored_len <= CAP_LIM)
      else $error("stored length beyond capture limit");
   chk_magic_nostore: assert property (magic_evt && !pkt_wake && !stored_valid && !alt_rst |=> !stored_valid)
      else $error("magic frame stored");

   cov_magic_wake: cover property (magic_evt ##1 pme_status);
   cov_pattern_store: cover property (pkt_wake && !stored_valid ##1 stored_valid);
   cov_iso_release: cover property (iso ##1 !iso ##1 internal_init);
   cov_bar_active: cover property (pm_state == PS_D0U ##1 pm_state == PS_D0A);
endmodule : pswr_ctrl

//--- hw/pswr_sync2.sv
`timescale 1ns/1ns
module pswr_sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // asynchronous in, synchronous out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   // two flip-flop chain, first stage read only by second
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : pswr_sync2
